// ### hdl/operand_address_decoder.sv
// operand address decoder: collects operand bytes after an opcode and forms
// the immediate value or effective address
// assumes the fetch stream offers one byte per valid beat, same clock
`timescale 1ns/100ps
`default_nettype none

module operand_address_decoder
    import operand_decode_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire decode_request_type request,
    input wire logic [7:0] index_first,
    input wire logic [7:0] index_second,
    input wire logic fetch_valid,
    input wire logic [7:0] fetch_byte,
    output logic fetch_ready,
    output logic busy,
    output logic done,
    output operand_result_type result
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {st_idle, st_first, st_second} state_type;

    state_type state_q, state_d;
    addr_mode_type mode_q, mode_d;
    logic [7:0] index_q, index_d;
    logic [7:0] high_q, high_d;
    logic done_q, done_d;
    operand_result_type result_q, result_d;

    // bytes that follow the opcode for a given mode
    function automatic logic [1:0] operand_bytes(input addr_mode_type m);
        case (m)
            mode_immediate: operand_bytes = 2'h1;
            mode_direct_short: operand_bytes = 2'h1;
            mode_direct_long: operand_bytes = 2'h2;
            mode_indexed_none: operand_bytes = 2'h0;
            mode_indexed_short: operand_bytes = 2'h1;
            mode_indexed_long: operand_bytes = 2'h2;
            default: operand_bytes = 2'h0;
        endcase
    endfunction : operand_bytes

    assign fetch_ready = (state_q != st_idle);
    assign busy = (state_q != st_idle);
    assign done = done_q;
    assign result = result_q;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic [7:0] sel_index;
        sel_index = request.use_second_index ? index_second : index_first;
        state_d = state_q;
        mode_d = mode_q;
        index_d = index_q;
        high_d = high_q;
        done_d = 1'b0;
        result_d = result_q;
        case (state_q)
            st_idle:
            begin
                if (start)
                begin
                    mode_d = request.mode;
                    index_d = sel_index;
                    if (operand_bytes(request.mode) == 2'h0)
                    begin
                        // index alone, page zero only
                        result_d.is_value = 1'b0;
                        result_d.value = zero_byte;
                        result_d.address = {zero_byte, sel_index};
                        done_d = 1'b1;
                    end
                    else
                    begin
                        state_d = st_first;
                    end
                end
            end
            st_first:
            begin
                if (fetch_valid)
                begin
                    case (mode_q)
                        mode_immediate:
                        begin
                            // value used as is, no data access
                            result_d.is_value = 1'b1;
                            result_d.value = fetch_byte;
                            result_d.address = zero_addr;
                            done_d = 1'b1;
                            state_d = st_idle;
                        end
                        mode_direct_short:
                        begin
                            result_d.is_value = 1'b0;
                            result_d.value = zero_byte;
                            result_d.address = {zero_byte, fetch_byte};
                            done_d = 1'b1;
                            state_d = st_idle;
                        end
                        mode_indexed_short:
                        begin
                            // nine-bit sum: carry kept, never wraps
                            result_d.is_value = 1'b0;
                            result_d.value = zero_byte;
                            result_d.address = {zero_byte, index_q}
                                + {zero_byte, fetch_byte};
                            done_d = 1'b1;
                            state_d = st_idle;
                        end
                        default:
                        begin
                            high_d = fetch_byte;
                            state_d = st_second;
                        end
                    endcase
                end
            end
            st_second:
            begin
                if (fetch_valid)
                begin
                    result_d.is_value = 1'b0;
                    result_d.value = zero_byte;
                    if (mode_q == mode_indexed_long)
                    begin
                        // 16-bit wrap at top of space is inherent
                        result_d.address = {high_q, fetch_byte}
                            + {zero_byte, index_q};
                    end
                    else
                    begin
                        result_d.address = {high_q, fetch_byte};
                    end
                    done_d = 1'b1;
                    state_d = st_idle;
                end
            end
            default:
            begin
                state_d = st_idle;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q <= st_idle;
            mode_q <= mode_immediate;
            index_q <= zero_byte;
            high_q <= zero_byte;
            done_q <= 1'b0;
            result_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            mode_q <= mode_d;
            index_q <= index_d;
            high_q <= high_d;
            done_q <= done_d;
            result_q <= result_d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_immediate_value;
        @(posedge clk) disable iff (reset)
        (state_q == st_first && fetch_valid && mode_q == mode_immediate)
            |=> (done && result.is_value && result.value == $past(fetch_byte));
    endproperty
    a_immediate_value: assert property (p_immediate_value)
        else $error("immediate value not taken from operand byte");

    property p_short_direct;
        @(posedge clk) disable iff (reset)
        (state_q == st_first && fetch_valid && mode_q == mode_direct_short)
            |=> (done && result.address == {8'h00, $past(fetch_byte)});
    endproperty
    a_short_direct: assert property (p_short_direct)
        else $error("short direct address wrong");

    property p_long_direct;
        @(posedge clk) disable iff (reset)
        (state_q == st_second && fetch_valid && mode_q == mode_direct_long)
            |=> (done && result.address == {$past(high_q), $past(fetch_byte)});
    endproperty
    a_long_direct: assert property (p_long_direct)
        else $error("long direct address wrong");

    property p_no_offset;
        @(posedge clk) disable iff (reset)
        (state_q == st_idle && start && request.mode == mode_indexed_none)
            |=> (done && state_q == st_idle
                && result.address == {8'h00, ($past(request.use_second_index)
                    ? $past(index_second) : $past(index_first))});
    endproperty
    a_no_offset: assert property (p_no_offset)
        else $error("indexed no-offset fetched or left page zero");

    property p_short_indexed;
        @(posedge clk) disable iff (reset)
        (state_q == st_first && fetch_valid && mode_q == mode_indexed_short)
            |=> (result.address == 16'($past(index_q)) + 16'($past(fetch_byte)));
    endproperty
    a_short_indexed: assert property (p_short_indexed)
        else $error("short indexed sum wrong");

    property p_long_indexed;
        @(posedge clk) disable iff (reset)
        (state_q == st_second && fetch_valid && mode_q == mode_indexed_long)
            |=> (result.address
                == 16'({$past(high_q), $past(fetch_byte)} + 16'($past(index_q))));
    endproperty
    a_long_indexed: assert property (p_long_indexed)
        else $error("long indexed sum wrong");

    property p_two_byte_count;
        @(posedge clk) disable iff (reset)
        (state_q == st_idle && start && request.mode == mode_direct_long)
            |=> (state_q == st_first && !done);
    endproperty
    a_two_byte_count: assert property (p_two_byte_count)
        else $error("long direct did not wait for operand bytes");

    property p_high_first;
        @(posedge clk) disable iff (reset)
        (state_q == st_first && fetch_valid && mode_q == mode_indexed_long)
            |=> (high_q == $past(fetch_byte) && state_q == st_second);
    endproperty
    a_high_first: assert property (p_high_first)
        else $error("first operand byte not kept as high half");

endmodule : operand_address_decoder

`default_nettype wire

// ### hdl/operand_decode_pkg.sv
// operand addressing definitions for the 8-bit core decoder
// assumes a byte-wide fetch stream and a 16-bit data address space
package operand_decode_pkg;

    localparam int byte_w = 8;
    localparam int addr_w = 16;
    localparam logic [7:0] zero_byte = 8'h00;
    localparam logic [15:0] zero_addr = 16'h0000;

    typedef enum logic [2:0] {
        mode_immediate,
        mode_direct_short,
        mode_direct_long,
        mode_indexed_none,
        mode_indexed_short,
        mode_indexed_long
    } addr_mode_type;

    // instruction start as seen by the decoder
    typedef struct packed {
        addr_mode_type mode;
        logic use_second_index;
    } decode_request_type;

    // decoded operand handed to the execute stage
    typedef struct packed {
        logic is_value;
        logic [7:0] value;
        logic [15:0] address;
    } operand_result_type;

endpackage : operand_decode_pkg

// ### sim/fetch_stream_model.sv
// fetch stream partner: offers queued operand bytes one per beat
// assumes the bench pushes bytes into q; random stalls between beats
`timescale 1ns/100ps
`default_nettype none

module fetch_stream_model
(
    input wire logic clk,
    input wire logic reset,
    input wire logic fetch_ready,
    output logic fetch_valid,
    output logic [7:0] fetch_byte
);
    logic [7:0] q[$];
    int stall_seed = 37226;

    // ---------------------------------------------------------------
    // byte offer
    // ---------------------------------------------------------------
    // idle beats show a changing pattern so stale bytes never look valid
    always @(posedge clk)
    begin
        if (reset)
        begin
            fetch_valid <= 1'b0;
            fetch_byte <= 8'h00;
        end
        else
        begin
            if (fetch_valid && fetch_ready)
            begin
                void'(q.pop_front());
            end
            if (q.size() > 0 && ($random(stall_seed) % 3) != 0)
            begin
                fetch_valid <= 1'b1;
                fetch_byte <= q[0];
            end
            else
            begin
                fetch_valid <= 1'b0;
                fetch_byte <= ~fetch_byte;
            end
        end
    end

endmodule : fetch_stream_model

`default_nettype wire

// ### sim/operand_address_decoder_tb.sv
// testbench for the operand address decoder
// assumes the fetch stream model stands on the operand byte side
`timescale 1ns/100ps
`default_nettype none

module operand_address_decoder_tb;
    import operand_decode_pkg::*;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    decode_request_type request = '0;
    logic [7:0] index_first = 8'h00;
    logic [7:0] index_second = 8'h00;
    logic fetch_valid;
    logic [7:0] fetch_byte;
    logic fetch_ready;
    logic busy;
    logic done;
    operand_result_type result;
    int seed = 37226;
    int error_cnt = 0;
    int tests_run = 0;

    always #5 clk = ~clk;

    operand_address_decoder uut (.clk(clk), .reset(reset), .start(start), .request(request),
        .index_first(index_first), .index_second(index_second), .fetch_valid(fetch_valid),
        .fetch_byte(fetch_byte), .fetch_ready(fetch_ready), .busy(busy), .done(done),
        .result(result));

    fetch_stream_model model (.clk(clk), .reset(reset), .fetch_ready(fetch_ready),
        .fetch_valid(fetch_valid), .fetch_byte(fetch_byte));

    // ---------------------------------------------------------------
    // expectations and compares
    // ---------------------------------------------------------------
    function automatic operand_result_type expect_result(addr_mode_type m, logic s,
        logic [7:0] x1, logic [7:0] x2, logic [7:0] b0, logic [7:0] b1);
        operand_result_type r;
        logic [15:0] ix;
        r = '0;
        ix = {8'h00, s ? x2 : x1};
        case (m)
            mode_immediate:
            begin
                r.is_value = 1'b1;
                r.value = b0;
            end
            mode_direct_short: r.address = {8'h00, b0};
            mode_direct_long: r.address = {b0, b1};
            mode_indexed_none: r.address = ix;
            mode_indexed_short: r.address = ix + {8'h00, b0};
            default: r.address = ix + {b0, b1};
        endcase
        return r;
    endfunction : expect_result

    task automatic compare_result(operand_result_type got, operand_result_type exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare_result

    task automatic compare_bit(logic got, logic exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare_bit

    // ---------------------------------------------------------------
    // one instruction: start, feed operand bytes, check the answer
    // ---------------------------------------------------------------
    task automatic run_op(addr_mode_type m, logic s, logic [7:0] x1, logic [7:0] x2,
        logic [7:0] b0, logic [7:0] b1);
        operand_result_type e;
        int k;
        e = expect_result(m, s, x1, x2, b0, b1);
        @(posedge clk);
        start <= 1'b1;
        request <= '{mode: m, use_second_index: s};
        index_first <= x1;
        index_second <= x2;
        if (m inside {mode_immediate, mode_direct_short, mode_direct_long,
            mode_indexed_short, mode_indexed_long}) model.q.push_back(b0);
        if (m inside {mode_direct_long, mode_indexed_long}) model.q.push_back(b1);
        @(posedge clk);
        start <= 1'b0;
        // index changes after start must not reach the address
        index_first <= ~x1;
        index_second <= ~x2;
        k = 0;
        #1;
        compare_bit(busy, m != mode_indexed_none);
        compare_bit(fetch_ready, m != mode_indexed_none);
        while (done !== 1'b1 && k < 30)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        compare_bit(done, 1'b1);
        compare_result(result, e);
        compare_bit(model.q.size() == 0, 1'b1);
    endtask : run_op

    task automatic final_report();
        if (error_cnt == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    initial
    begin
        #50000;
        error_cnt++;
        final_report();
    end

    initial
    begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        // boundary sums: 1fe ceiling and 64k wrap
        run_op(mode_indexed_short, 1'b0, 8'hff, 8'h00, 8'hff, 8'h00);
        run_op(mode_indexed_long, 1'b1, 8'h00, 8'hff, 8'hff, 8'hff);
        run_op(mode_indexed_none, 1'b1, 8'h12, 8'hab, 8'h00, 8'h00);
        run_op(mode_immediate, 1'b0, 8'h55, 8'h66, 8'h00, 8'h00);
        for (int i = 0; i < 6; i++)
            run_op(addr_mode_type'(i), 1'(i), 8'h80, 8'h7f, 8'hc3, 8'h3c);
        // abort a long operand with reset after its high byte
        @(posedge clk);
        start <= 1'b1;
        request <= '{mode: mode_indexed_long, use_second_index: 1'b0};
        model.q.push_back(8'h9a);
        @(posedge clk);
        // a second start while collecting must be ignored
        request <= '{mode: mode_indexed_none, use_second_index: 1'b0};
        @(posedge clk);
        start <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        compare_bit(busy & !done, 1'b1);
        reset <= 1'b1;
        model.q.delete();
        repeat (2) @(posedge clk);
        #1;
        compare_bit(busy | done | fetch_ready | (|result), 1'b0);
        reset <= 1'b0;
        repeat (80)
            run_op(addr_mode_type'($unsigned($random(seed)) % 6), 1'($random(seed)),
                8'($random(seed)), 8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
        final_report();
    end
endmodule : operand_address_decoder_tb

`default_nettype wire
